//--- test/bhs_opto_model.sv
`timescale 1ns/10ps
module bhs_opto_model (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        high_side_drive_i,
  input  wire logic [15:0] want_i,
  output logic             feedback_request_o,
  output logic [15:0]      done_o
);
  logic hg_reg;
  // Credit a cycle on HG fall, once its energy is delivered
  always_ff @(posedge clk_sys_i) begin
    hg_reg <= high_side_drive_i;
    if (sys_rst_i) begin
      done_o <= 16'h0000;
    end else if (hg_reg && !high_side_drive_i) begin
      done_o <= done_o + 16'h0001;
    end
  end
  // Output stays below regulation until the wanted cycles arrived
  assign feedback_request_o = done_o < want_i;
endmodule

//--- test/bhs_sva.sv
`timescale 1ns/10ps
module bhs_sva (
  input wire logic           clk_sys_i,
  input wire logic           sys_rst_i,
  input bhs_pkg::bhs_sense_t sense_i,
  input wire logic           low_side_drive_o,
  input wire logic           high_side_drive_o,
  input wire logic           clamp_o,
  input wire logic           start_o,
  input wire logic           fault_o
);
  import bhs_pkg::*;
  wire        ls = low_side_drive_o;
  wire        hs = high_side_drive_o;
  logic [7:0] hs_run_reg;
  logic [7:0] ls_run_reg;
  // Run lengths of each drive, so phase widths can be tied to exact counts
  always_ff @(posedge clk_sys_i) begin
    hs_run_reg <= hs ? hs_run_reg + 8'h01 : 8'h00;
    ls_run_reg <= ls ? ls_run_reg + 8'h01 : 8'h00;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  clamp_match_a: assert property (clamp_o == !(ls || hs)) else $error("clamp wrong");
  drive_exclusive_a: assert property (!(ls && hs)) else $error("drives overlap");
  hs_length_a: assert property ($fell(hs) |-> ls && hs_run_reg == 8'd40)
    else $error("high side length");
  hs_entry_a: assert property ($rose(hs) |-> ls_run_reg == 8'd20 || ls_run_reg == 8'd40)
    else $error("low side head");
  ls_tail_a: assert property ($rose(clamp_o) |-> ls_run_reg == 8'd20) else $error("low side tail");
  fault_quiet_a: assert property (fault_o |-> clamp_o && !start_o) else $error("active in fault");
  fault_latch_a: assert property (fault_o |=> fault_o) else $error("fault dropped");
  fault_at_end_a: assert property ($rose(fault_o) |-> clamp_o) else $error("fault mid cycle");
  ovp_idle_a: assert property (sense_i.bus_overvoltage_trip && clamp_o |=> fault_o)
    else $error("idle trip missed");
  bus_gate_a: assert property ($fell(clamp_o) |-> $past(sense_i.bus_sense_input)
    && !$past(sense_i.bus_undervoltage)) else $error("start without bus");
  fault_c: cover property ($rose(fault_o));
  normal_c: cover property ($rose(start_o));
  chain_c: cover property ($rose(hs) && ls_run_reg == 8'd40);
endmodule
bind bhs_sequencer bhs_sva chk_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sense_i(sense_i),
  .low_side_drive_o(low_side_drive_o), .high_side_drive_o(high_side_drive_o), .clamp_o(clamp_o),
  .start_o(start_o), .fault_o(fault_o));

//--- test/burst_halfbridge_sequencer_bench.sv
`timescale 1ns/10ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t %s", $time, m); end end
module burst_halfbridge_sequencer_bench;
  import bhs_pkg::*;
  logic        clk_sys_i;
  logic        sys_rst_i;
  bhs_sense_t  sense;
  logic        req, lsd, hsd, cl, st, ft;
  logic [15:0] want, done;
  int          n_mismatch, n_compared, len, nh, nl;
  bhs_sequencer #(.STARTUP_CYCLES(20), .RAMP_CYCLES(2000)) dut_u (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .sense_i(sense), .feedback_request_i(req), .low_side_drive_o(lsd),
    .high_side_drive_o(hsd), .clamp_o(cl), .start_o(st), .fault_o(ft));
  bhs_opto_model far_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .high_side_drive_i(hsd),
    .want_i(want), .feedback_request_o(req), .done_o(done));
  task automatic test_done();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic drive(logic [2:0] s, logic [15:0] w);
    @(posedge clk_sys_i);
    sense <= s;
    want <= w;
    #1;
  endtask
  function automatic bit seen(int sel);
    return sel == 0 ? cl === 1'b0 : sel == 1 ? st === 1'b1 : cl === 1'b1;
  endfunction
  task automatic wait_for(int sel, int lim);
    int i;
    for (i = 0; i < lim && !seen(sel); i++) tick(1);
    if (i == lim) begin
      n_mismatch++;
      $display("BAD %0t timeout", $time);
      test_done();
    end
  endtask
  // Counts one burst from its first clock to the return of clamp
  task automatic measure();
    len = 0;
    nh = 0;
    nl = 0;
    wait_for(0, 3000);
    while (cl === 1'b0 && len < 2000) begin
      len++;
      nh += int'(hsd === 1'b1);
      nl += int'(lsd === 1'b1);
      tick(1);
    end
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    sys_rst_i = 1'b1;
    sense = 3'b000;
    want = 16'h0000;
    n_mismatch = 0;
    n_compared = 0;
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    tick(1);
    `CHK({cl, st, ft, lsd, hsd}, 5'b10000, "reset")
    drive(3'b100, 16'hffff);
    tick(18);
    `CHK(cl, 1'b1, "early switching")
    measure();
    `CHK(len, 80, "ramp cycle")
    `CHK(nh, nl, "balance")
    `CHK(nh, 40, "high side time")
    `CHK(st, 1'b0, "start in ramp")
    wait_for(1, 2500);
    `CHK(st, 1'b1, "ramp timeout")
    drive(3'b100, done);
    wait_for(2, 200);
    tick(30);
    `CHK(cl, 1'b1, "dropout")
    drive(3'b100, done + 16'd3);
    measure();
    `CHK(len, 320, "burst")
    `CHK(nh, 160, "burst samples")
    drive(3'b100, done + 16'd9);
    wait_for(0, 100);
    tick(10);
    drive(3'b110, want);
    measure();
    `CHK(nh, 40, "uv finish")
    tick(40);
    `CHK({cl, st}, 2'b10, "uv stop")
    // One ramp cycle satisfies the request, so the ramp must end early
    drive(3'b100, done + 16'd1);
    wait_for(1, 300);
    `CHK(st, 1'b1, "ramp cut by request")
    drive(3'b100, done + 16'd9);
    wait_for(0, 300);
    drive(3'b101, want);
    `CHK(ft, 1'b0, "fault mid cycle")
    measure();
    `CHK(nh, 40, "fault finish")
    `CHK({ft, st}, 2'b10, "fault latch")
    drive(3'b100, 16'hffff);
    tick(300);
    `CHK({ft, cl}, 2'b11, "latched")
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    drive(3'b101, 16'h0000);
    tick(1);
    `CHK(ft, 1'b1, "idle trip")
    test_done();
  end
endmodule

//--- verilog/bhs_cycle.sv
`timescale 1ns/10ps
// One whole switching cycle: low quarter, high half, low quarter
module bhs_cycle (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              start_i,
  output bhs_pkg::bhs_drive_t    drive_o,
  output logic                   busy_o,
  output logic                   sample_o,
  output logic                   last_o
);
  import bhs_pkg::*;

  typedef struct packed {
    logic       run;
    logic [7:0] cnt;
    bhs_drive_t drv;
  } bhs_cyc_state_t;

  bhs_cyc_state_t s_reg;
  bhs_cyc_state_t s_next;
  logic           run_n;
  logic [7:0]     cnt_n;

  always_comb begin
    s_next = s_reg;
    run_n  = s_reg.run;
    cnt_n  = s_reg.cnt;
    if (s_reg.run) begin
      if (s_reg.cnt == CYC_LAST) begin
        cnt_n = 8'h00;
        run_n = start_i;
      end else begin
        cnt_n = s_reg.cnt + 8'h01;
      end
    end else if (start_i) begin
      run_n = 1'b1;
      cnt_n = 8'h00;
    end
    s_next.run = run_n;
    s_next.cnt = cnt_n;
    // No internal dead time; equal low and high on-time [RULE20] [RULE18]
    s_next.drv.low_side_drive  = run_n && (cnt_n < LS1_END || cnt_n >= HS_END); // [RULE19]
    s_next.drv.high_side_drive = run_n && cnt_n >= LS1_END && cnt_n < HS_END; // [RULE19]
    s_next.drv.clamp           = !run_n; // [RULE24]
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_reg     <= '0;
      s_reg.drv <= 3'b001;
    end else begin
      s_reg <= s_next;
    end
  end

  assign drive_o  = s_reg.drv;
  assign busy_o   = s_reg.run;
  assign sample_o = s_reg.run && s_reg.cnt == REQ_SAMPLE_PT;
  assign last_o   = s_reg.run && s_reg.cnt == CYC_LAST;
endmodule

//--- verilog/bhs_pkg.sv
package bhs_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 10_000_000;

  // Switching cycle: nominal 8 us period, low quarter, high half, low quarter
  localparam int unsigned CYCLE_NS        = 8000;
  localparam int unsigned CYCLE_CYC       = CYCLE_NS / (1_000_000_000 / CLK_HZ);
  localparam logic [7:0]  CYC_LAST        = 8'(CYCLE_CYC - 1);
  localparam logic [7:0]  LS1_END         = 8'(CYCLE_CYC / 4);
  localparam logic [7:0]  HS_END          = 8'((CYCLE_CYC * 3) / 4);
  localparam logic [7:0]  REQ_SAMPLE_PT   = 8'(CYCLE_CYC / 2);

  // Start-up delay and ramp timing
  localparam int unsigned STARTUP_US      = 10_000;
  localparam int unsigned STARTUP_CYC     = STARTUP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RAMP_MS         = 20;
  localparam int unsigned RAMP_CYC        = RAMP_MS * (CLK_HZ / 1000);

  // Off-interval schedule, in cycles of clk
  localparam int unsigned RAMP_DUTY_PCT   = 95;
  localparam int unsigned OFF_MIN_CYC_I   = (CYCLE_CYC * (100 - RAMP_DUTY_PCT) + RAMP_DUTY_PCT - 1) / RAMP_DUTY_PCT;
  localparam int unsigned OFF_MAX_CYC_I   = 8000;
  localparam logic [15:0] OFF_MIN_CYC     = 16'(OFF_MIN_CYC_I);
  localparam logic [15:0] OFF_MAX_CYC     = 16'(OFF_MAX_CYC_I);
  localparam int unsigned RAMP_PULSES     = 50;
  localparam logic [15:0] OFF_STEP        = 16'((OFF_MAX_CYC_I - OFF_MIN_CYC_I) / RAMP_PULSES);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DELAY  = 3'b001,
    ST_RAMP   = 3'b010,
    ST_NORMAL = 3'b011,
    ST_FAULT  = 3'b100
  } bhs_state_t;

  // Analog comparator inputs
  typedef struct packed {
    logic bus_sense_input;
    logic bus_undervoltage;
    logic bus_overvoltage_trip;
  } bhs_sense_t;

  // Drive outputs
  typedef struct packed {
    logic low_side_drive;
    logic high_side_drive;
    logic clamp;
  } bhs_drive_t;

endpackage

//--- verilog/bhs_sequencer.sv
`timescale 1ns/10ps
// How it works
// [RULE1] Switching allowed only while bus sense is above undervoltage enable.
// [RULE2] On undervoltage finish current cycle, then stop until bus rises again.
// [RULE3] After bus enable rises, wait fixed start-up delay before switching.
// [RULE4] Overvoltage trip is a fault leading to latched shutdown.
// [RULE5] Fault during a cycle: complete cycle, latch fault at its end.
// [RULE6] Overvoltage with no cycle running latches the fault at once.
// [RULE7] Latched overvoltage shows on the fault output for upstream shutdown.
// [RULE8] After delay, ramp mode: single cycles with shrinking off-intervals.
// [RULE9] Ramp off-interval never below fixed minimum, capping duty near 95%.
// [RULE10] Feedback low during ramp ends the ramp and starts normal mode.
// [RULE11] At end of nominal ramp interval move to normal mode anyway.
// [RULE12] Normal mode can run cycles back to back with no gap.
// [RULE13] Normal mode starts a cycle whenever feedback request is high.
// [RULE14] Every started cycle runs to completion regardless of feedback.
// [RULE15] Feedback high at sample continues contiguously; low stops at cycle end.
// [RULE16] Feedback sampled exactly once per switching cycle.
// [RULE17] After dropout keep watching feedback; restart on its next high.
// [RULE18] Low-side and high-side get equal total on-time per cycle.
// [RULE19] Cycle order low, high, low; each low half the high time.
// [RULE20] No internal dead time; external drivers provide any needed.
// [RULE21] Feedback path holds request high below regulation, low above.
// [RULE22] Start output low until normal mode, high in normal, low in fault.
// [RULE23] Fault output high exactly while in latched fault state.
// [RULE24] Clamp output high whenever both drive outputs are inactive.
// [RULE25] In fault both drives stay inactive until power-on reset.
// [RULE26] Ramp off-interval falls in fixed steps from maximum to minimum.
module bhs_sequencer #(
  parameter int unsigned STARTUP_CYCLES = bhs_pkg::STARTUP_CYC,
  parameter int unsigned RAMP_CYCLES    = bhs_pkg::RAMP_CYC
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  bhs_pkg::bhs_sense_t    sense_i,
  input  wire logic              feedback_request_i,
  output logic                   low_side_drive_o,
  output logic                   high_side_drive_o,
  output logic                   clamp_o,
  output logic                   start_o,
  output logic                   fault_o
);
  import bhs_pkg::*;

  localparam logic [23:0] STARTUP_LAST = 24'(STARTUP_CYCLES - 1);
  localparam logic [23:0] RAMP_LAST    = 24'(RAMP_CYCLES - 1);

  typedef struct packed {
    bhs_state_t  st;
    logic [23:0] tmr;       // Start-up delay and ramp interval timer
    logic [15:0] off_len;   // Current ramp off-interval
    logic [15:0] off_cnt;   // Off-interval countdown
    logic        fb_keep;   // Feedback sample taken this cycle
    logic        fault_pend;
    logic        start;
    logic        fault;
  } bhs_seq_state_t;

  bhs_seq_state_t s_reg;
  bhs_seq_state_t s_next;
  bhs_drive_t     drv;
  logic           cyc_busy;
  logic           cyc_sample;
  logic           cyc_last;
  logic           cyc_start;
  logic           bus_ok;

  // Comparator result: bus above enable level and not flagged undervoltage
  assign bus_ok = sense_i.bus_sense_input && !sense_i.bus_undervoltage; // [RULE1]

  bhs_cycle u_cycle (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (cyc_start),
    .drive_o   (drv),
    .busy_o    (cyc_busy),
    .sample_o  (cyc_sample),
    .last_o    (cyc_last)
  );

  // Next off-interval, clipped so it never drops under the minimum
  function automatic logic [15:0] next_off(input logic [15:0] cur);
    if (cur <= OFF_MIN_CYC + OFF_STEP) begin
      next_off = OFF_MIN_CYC; // [RULE9]
    end else begin
      next_off = cur - OFF_STEP; // [RULE26]
    end
  endfunction

  // Request to start (or chain) a cycle; only consulted when idle or at the last count
  always_comb begin
    cyc_start = 1'b0;
    case (s_reg.st)
      ST_RAMP: begin
        // Single isolated cycles after the off-interval expires
        // An idle trip latches the fault this edge, so it must not start a cycle too
        cyc_start = bus_ok && !cyc_busy && s_reg.off_cnt == 16'h0000 && !s_reg.fault_pend
                    && !sense_i.bus_overvoltage_trip; // [RULE8] [RULE25]
      end
      ST_NORMAL: begin
        if (cyc_busy) begin
          // Chain only on the one sample taken this cycle
          cyc_start = s_reg.fb_keep && bus_ok && !s_reg.fault_pend && !sense_i.bus_overvoltage_trip; // [RULE15] [RULE12]
        end else begin
          cyc_start = feedback_request_i && bus_ok && !sense_i.bus_overvoltage_trip; // [RULE13] [RULE17]
        end
      end
      default: cyc_start = 1'b0;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    // Sample the feedback once per cycle, hold it for the chaining decision
    if (cyc_sample) begin
      s_next.fb_keep = feedback_request_i; // [RULE16]
    end
    // Faults seen while a cycle runs wait for its end
    if (sense_i.bus_overvoltage_trip && cyc_busy) begin
      s_next.fault_pend = 1'b1; // [RULE5]
    end

    case (s_reg.st)
      ST_IDLE: begin
        s_next.tmr = 24'h000000;
        if (bus_ok && !cyc_busy) begin
          s_next.st = ST_DELAY; // [RULE3]
        end
      end
      ST_DELAY: begin
        if (!bus_ok) begin
          s_next.st = ST_IDLE;
        end else if (s_reg.tmr == STARTUP_LAST) begin
          s_next.st      = ST_RAMP; // [RULE8]
          s_next.tmr     = 24'h000000;
          s_next.off_len = OFF_MAX_CYC; // [RULE26]
          s_next.off_cnt = 16'h0000;
        end else begin
          s_next.tmr = s_reg.tmr + 24'h000001; // [RULE3]
        end
      end
      ST_RAMP: begin
        s_next.tmr = s_reg.tmr + 24'h000001;
        if (cyc_last) begin
          s_next.off_cnt = s_reg.off_len;
          s_next.off_len = next_off(s_reg.off_len); // [RULE26]
        end else if (!cyc_busy && s_reg.off_cnt != 16'h0000) begin
          s_next.off_cnt = s_reg.off_cnt - 16'h0001;
        end
        // Leave ramp only between cycles so a started cycle is never cut
        if (!feedback_request_i || s_reg.tmr >= RAMP_LAST) begin
          if (!cyc_busy || cyc_last) begin
            s_next.st = ST_NORMAL; // [RULE10] [RULE11]
          end
        end
        if (!bus_ok && (!cyc_busy || cyc_last)) begin
          s_next.st = ST_IDLE; // [RULE2]
        end
      end
      ST_NORMAL: begin
        if (!bus_ok && (!cyc_busy || cyc_last)) begin
          s_next.st = ST_IDLE; // [RULE2] [RULE14]
        end
      end
      ST_FAULT: begin
        s_next.st = ST_FAULT; // [RULE25]
      end
      default: s_next.st = ST_IDLE;
    endcase

    // Overvoltage: immediate when idle, at cycle end otherwise
    if (s_reg.st != ST_FAULT) begin
      if ((sense_i.bus_overvoltage_trip && !cyc_busy) || (cyc_last && s_next.fault_pend)) begin
        s_next.st = ST_FAULT; // [RULE4] [RULE6] [RULE5]
      end
    end

    s_next.start = s_next.st == ST_NORMAL; // [RULE22]
    s_next.fault = s_next.st == ST_FAULT; // [RULE23] [RULE7]
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_reg    <= '0;
      s_reg.st <= ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Drives come from flops in the cycle engine; fault cannot start a new cycle
  assign low_side_drive_o  = drv.low_side_drive;
  assign high_side_drive_o = drv.high_side_drive;
  assign clamp_o           = drv.clamp; // [RULE24]
  assign start_o           = s_reg.start;
  assign fault_o           = s_reg.fault;
endmodule
